// ==== rtl/ebcs_bus.sv ====
// External bus cycle sequencer: byte enables, write strobes, bus size
// and the shared strobe/enable pin, plus a small register port.
// Assumes requests come from logic on clk; pins are floated (pulled up
// outside) while reset or bus hold is in effect.
//
// Contract
// [R1] A word cycle drives byte high enable and address bit zero low; a high byte cycle drives enable low and bit zero high.
// [R2] A low byte cycle drives byte high enable high with address bit zero low.
// [R3] A refresh cycle drives both byte high enable and address bit zero high.
// [R4] Outside logic decodes refresh from those two pins, not from the address bus.
// [R5] Separate low and high byte write strobes mirror the byte lane decode on writes.
// [R6] The bus size pin is asserted for an 8-bit cycle and released for a 16-bit one.
// [R7] The bus size and strobe pins are floated to their pulled-up idle level in reset or hold.
// [R8] In strobe mode reads and writes use the same cycle timing.
// [R9] Strobe mode with the other control pins forms a direct 68K-style interface.
// [R10] On writes data stays on the AD bus while the strobe is low, and the address is valid all the while.
// [R11] On reads a peripheral drives AD once the strobe is low and stops when it rises.
// [R12] The shared pin acts either as data strobe or as data enable, chosen by configuration.
//
// The register addresses and the plain strobed port are this design's own decisions.

`timescale 1ns/1ps
`default_nettype none

module ebcs_bus (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output var  logic [31:0]        reg_rdata,
    input  wire logic               req_valid,
    input  wire ebcs_pkg::ebcs_req_t req,
    output var  logic               req_ready,
    output var  logic               rsp_valid,
    output var  logic [15:0]        rsp_rdata,
    input  wire logic               hold_req,
    output var  logic               hold_ack,
    input  wire logic [15:0]        ad_in,
    output var  ebcs_pkg::ebcs_pins_t pins
);
    import ebcs_pkg::*;

    // ------------------------------------------------------------------
    // Local constants and state
    // ------------------------------------------------------------------

    // Final count of the strobe phase; the strobe stands one cycle more
    // than this, long enough for a slow peripheral at this clock rate
    localparam logic [3:0] CNT_LAST = 4'(STROBE_CYCLES - 1);

    typedef struct packed {
        ebcs_phase_t phase;
        logic [3:0]  cnt;
        logic        mode_ds;
        logic        cyc_ds;
        ebcs_req_t   cyc;
        logic        req_ready;
        logic        rsp_valid;
        logic [15:0] rsp_rdata;
        logic        hold_ack;
        logic [31:0] reg_rdata;
        ebcs_pins_t  pins;
    } ebcs_bus_st_t;

    localparam ebcs_bus_st_t ST_RESET = '{
        phase:     PH_IDLE,
        cnt:       4'h0,
        mode_ds:   CTRL_DS_RESET,
        cyc_ds:    CTRL_DS_RESET,
        cyc:       '0,
        req_ready: 1'b0,
        rsp_valid: 1'b0,
        rsp_rdata: 16'h0000,
        hold_ack:  1'b0,
        reg_rdata: 32'h00000000,
        pins:      PINS_RESET
    };

    ebcs_bus_st_t st_q;
    ebcs_bus_st_t st_d;
    logic         hold_s;
    logic [15:0]  ad_s;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------

    // Hold request and read data come from pins, outside this clock
    ebcs_sync #(
        .W (1)
    ) i_hold_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (hold_req),
        .q       (hold_s)
    );

    // Read data is only taken at the end of a long strobe, so a whole
    // word settles well before it is used and no skew reaches it
    ebcs_sync #(
        .W (16)
    ) i_ad_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (ad_in),
        .q       (ad_s)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic       bus_on;
        logic [1:0] lane_code;
        bus_on         = 1'b0;
        lane_code      = 2'b11;
        st_d           = st_q;
        st_d.rsp_valid = 1'b0;
        st_d.reg_rdata = 32'h00000000;

        // Register port; read data stands for exactly one cycle
        if (reg_wr && reg_addr == REG_CTRL)
            st_d.mode_ds = reg_wdata[CTRL_DS_BIT]; // R12
        if (reg_rd && reg_addr == REG_CTRL)
            st_d.reg_rdata[CTRL_DS_BIT] = st_q.mode_ds;
        else if (reg_rd && reg_addr == REG_STATUS)
        begin
            st_d.reg_rdata[STAT_BUSY_BIT] = (st_q.phase != PH_IDLE)
                                            && (st_q.phase != PH_HOLD);
            st_d.reg_rdata[STAT_HOLD_BIT] = st_q.hold_ack;
            st_d.reg_rdata[STAT_REFR_BIT] = st_q.cyc.refresh
                                            && (st_q.phase == PH_ADDR
                                            || st_q.phase == PH_STRB);
            st_d.reg_rdata[STAT_MODE_BIT] = st_q.mode_ds;
        end

        // Cycle sequencer
        unique case (st_q.phase)
            PH_IDLE:
            begin
                // A request shown ready is always taken, even when hold
                // arrives in the same cycle; hold waits for the next idle
                if (req_valid && st_q.req_ready)
                begin
                    st_d.phase  = PH_ADDR;
                    st_d.cyc    = req;
                    st_d.cyc_ds = st_q.mode_ds; // R12
                end
                else if (hold_s)
                    st_d.phase = PH_HOLD;
            end
            PH_ADDR:
            begin
                st_d.phase = PH_STRB;
                st_d.cnt   = 4'h0;
            end
            PH_STRB:
            begin
                if (st_q.cnt == CNT_LAST)
                begin
                    st_d.phase     = PH_RECOV;
                    st_d.rsp_valid = 1'b1;
                    if (!st_q.cyc.write && !st_q.cyc.refresh)
                        st_d.rsp_rdata = ad_s;
                end
                else
                    st_d.cnt = st_q.cnt + 4'h1;
            end
            PH_RECOV:
                st_d.phase = PH_IDLE;
            PH_HOLD:
            begin
                if (!hold_s)
                    st_d.phase = PH_IDLE;
            end
            default:
                st_d.phase = PH_IDLE;
        endcase

        // Handshake flags follow the phase being entered
        st_d.req_ready = (st_d.phase == PH_IDLE) && !hold_s;
        st_d.hold_ack  = (st_d.phase == PH_HOLD);
        bus_on         = (st_d.phase == PH_ADDR) || (st_d.phase == PH_STRB);

        // Lane code is {byte_high_enable_n, addr_bit_zero}; an empty lane
        // field goes out as a word so it never aliases the refresh code
        if (st_d.cyc.refresh)
            lane_code = 2'b11; // R3
        else
        begin
            unique case (st_d.cyc.lanes)
                LANES_WORD: lane_code = 2'b00; // R1
                LANES_HIGH: lane_code = 2'b01; // R1
                LANES_LOW:  lane_code = 2'b10; // R2
                default:    lane_code = 2'b00;
            endcase
        end

        // Pins are built from the phase being entered, so every pin
        // comes straight from a flip-flop and all move on one edge
        st_d.pins        = PINS_RESET;
        st_d.pins.ctl_oe = (st_d.phase != PH_HOLD); // R7
        if ((st_d.phase != PH_IDLE) && (st_d.phase != PH_HOLD))
            st_d.pins.addr = st_d.cyc.addr; // R10
        if (bus_on)
        begin
            st_d.pins.byte_high_enable_n = lane_code[1];
            st_d.pins.addr_bit_zero      = lane_code[0];
            st_d.pins.narrow_bus_size_n  = !st_d.cyc.narrow; // R6
        end
        if (st_d.phase == PH_ADDR)
        begin
            st_d.pins.ad_out = st_d.cyc.addr[15:0];
            st_d.pins.ad_oe  = 1'b1;
            // As data enable the pin opens the transceiver a phase
            // early; as data strobe it waits for the strobe phase
            st_d.pins.strobe_pin_n = st_d.cyc_ds; // R12
        end
        if (st_d.phase == PH_STRB)
        begin
            // Same length for reads and writes, so a 68K-style part
            // needs no glue to time its data
            st_d.pins.strobe_pin_n = 1'b0; // R8 R9
            if (st_d.cyc.write && !st_d.cyc.refresh)
            begin
                st_d.pins.ad_out = st_d.cyc.wdata; // R10
                st_d.pins.ad_oe  = 1'b1;
                st_d.pins.write_low_byte_strobe_n  = lane_code[0]; // R5
                st_d.pins.write_high_byte_strobe_n = lane_code[1]; // R5
            end
        end
    end

    // ------------------------------------------------------------------
    // State register and outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            st_q <= ST_RESET; // R7
        else
            st_q <= st_d;
    end

    assign reg_rdata = st_q.reg_rdata;
    assign req_ready = st_q.req_ready;
    assign rsp_valid = st_q.rsp_valid;
    assign rsp_rdata = st_q.rsp_rdata;
    assign hold_ack  = st_q.hold_ack;
    assign pins      = st_q.pins;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_strobe_falls;
        $fell(st_q.pins.strobe_pin_n) && st_q.cyc_ds;
    endsequence

    // Three low samples match the strobe counter at its default
    sequence s_strobe_three_low;
        (!st_q.pins.strobe_pin_n) [*3] ##1 st_q.pins.strobe_pin_n;
    endsequence

    a_word_encode: assert property ( // R1
        @(posedge clk) disable iff (!reset_n)
        (st_q.phase == PH_ADDR || st_q.phase == PH_STRB)
        && !st_q.cyc.refresh && st_q.cyc.lanes == LANES_WORD
        |-> !st_q.pins.byte_high_enable_n && !st_q.pins.addr_bit_zero)
        else $error("word cycle lane code wrong");

    a_low_encode: assert property ( // R2
        @(posedge clk) disable iff (!reset_n)
        (st_q.phase == PH_ADDR || st_q.phase == PH_STRB)
        && !st_q.cyc.refresh && st_q.cyc.lanes == LANES_LOW
        |-> st_q.pins.byte_high_enable_n && !st_q.pins.addr_bit_zero)
        else $error("low byte lane code wrong");

    a_refresh_encode: assert property ( // R3
        @(posedge clk) disable iff (!reset_n)
        (st_q.phase == PH_ADDR || st_q.phase == PH_STRB)
        && st_q.cyc.refresh
        |-> st_q.pins.byte_high_enable_n && st_q.pins.addr_bit_zero)
        else $error("refresh lane code wrong");

    a_write_lanes: assert property ( // R5
        @(posedge clk) disable iff (!reset_n)
        (!st_q.pins.write_low_byte_strobe_n
        || !st_q.pins.write_high_byte_strobe_n)
        |-> st_q.pins.write_low_byte_strobe_n == st_q.pins.addr_bit_zero
        && st_q.pins.write_high_byte_strobe_n
        == st_q.pins.byte_high_enable_n && st_q.cyc.write)
        else $error("write strobes disagree with lanes");

    a_size_pin: assert property ( // R6
        @(posedge clk) disable iff (!reset_n)
        (st_q.phase == PH_ADDR || st_q.phase == PH_STRB)
        |-> st_q.pins.narrow_bus_size_n == !st_q.cyc.narrow)
        else $error("bus size pin wrong");

    a_float_hold: assert property ( // R7
        @(posedge clk) disable iff (!reset_n)
        st_q.hold_ack
        |-> !st_q.pins.ctl_oe && st_q.pins.strobe_pin_n
        && st_q.pins.narrow_bus_size_n && !st_q.pins.ad_oe)
        else $error("pins driven during hold");

    a_strobe_length: assert property ( // R8
        @(posedge clk) disable iff (!reset_n)
        s_strobe_falls |-> s_strobe_three_low)
        else $error("strobe length wrong");

    a_write_data_hold: assert property ( // R10
        @(posedge clk) disable iff (!reset_n)
        !st_q.pins.strobe_pin_n && $past(st_q.pins.strobe_pin_n) == 1'b0
        && st_q.cyc_ds && st_q.cyc.write && !st_q.cyc.refresh
        |-> $stable(st_q.pins.ad_out) && $stable(st_q.pins.addr)
        && st_q.pins.ad_oe)
        else $error("write data moved under strobe");

    a_pin_meaning: assert property ( // R12
        @(posedge clk) disable iff (!reset_n)
        st_q.phase == PH_ADDR
        |-> st_q.pins.strobe_pin_n == st_q.cyc_ds)
        else $error("shared pin used in wrong meaning");
endmodule
`default_nettype wire

// ==== rtl/ebcs_pkg.sv ====
// Shared constants and types for the external bus cycle signal block.
// Assumes a single 125 MHz clock and a synchronous active-low reset.

package ebcs_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ        = 125;
    localparam int STROBE_MIN_NS  = 24;
    localparam int STROBE_CYCLES  = (STROBE_MIN_NS * CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam int         CTRL_DS_BIT     = 0;
    localparam logic       CTRL_DS_RESET   = 1'b0;
    localparam int         STAT_BUSY_BIT   = 0;
    localparam int         STAT_HOLD_BIT   = 1;
    localparam int         STAT_REFR_BIT   = 2;
    localparam int         STAT_MODE_BIT   = 3;

    // Byte lane selections of a request
    localparam logic [1:0] LANES_WORD = 2'h3;
    localparam logic [1:0] LANES_HIGH = 2'h2;
    localparam logic [1:0] LANES_LOW  = 2'h1;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDR,
        PH_STRB,
        PH_RECOV,
        PH_HOLD
    } ebcs_phase_t;

    typedef struct packed {
        logic        write;
        logic        refresh;
        logic        narrow;
        logic [1:0]  lanes;
        logic [19:0] addr;
        logic [15:0] wdata;
    } ebcs_req_t;

    typedef struct packed {
        logic [19:0] addr;
        logic [15:0] ad_out;
        logic        ad_oe;
        logic        ctl_oe;
        logic        byte_high_enable_n;
        logic        addr_bit_zero;
        logic        write_low_byte_strobe_n;
        logic        write_high_byte_strobe_n;
        logic        narrow_bus_size_n;
        logic        strobe_pin_n;
    } ebcs_pins_t;

    localparam ebcs_pins_t PINS_RESET = '{
        addr: 20'h00000, ad_out: 16'h0000, ad_oe: 1'b0, ctl_oe: 1'b0,
        byte_high_enable_n: 1'b1, addr_bit_zero: 1'b1,
        write_low_byte_strobe_n: 1'b1, write_high_byte_strobe_n: 1'b1,
        narrow_bus_size_n: 1'b1, strobe_pin_n: 1'b1};

endpackage

// ==== rtl/ebcs_sync.sv ====
// Two-stage synchroniser for inputs arriving from pins.
// Assumes the destination clock is clk; no logic reads the first stage.

`timescale 1ns/1ps
`default_nettype none

module ebcs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ebcs_sync_st_t;

    ebcs_sync_st_t st_q;
    ebcs_sync_st_t st_d;

    always_comb
    begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign q = st_q.s2;
endmodule

`default_nettype wire

// ==== verif/ebcs_partner.sv ====
// Far-side peripheral that answers reads on the AD bus.
// Assumes ad_oe marks the device driving AD (every address phase, and write data).
`timescale 1ns/1ps
`default_nettype none
module ebcs_partner (
    input  wire logic        clk,
    input  wire logic        strb_n,
    input  wire logic        ad_oe,
    output var  logic [15:0] ad
);
    logic [15:0] junk = 16'hA5A5;
    // Released bus toggles so a stale value never looks valid
    always @(posedge clk) junk <= ~junk;
    always_comb ad = (!strb_n && !ad_oe) ? 16'h3C5A : junk;
endmodule
`default_nettype wire

// ==== verif/ebcs_bus_tb_top.sv ====
// Bench for the bus sequencer: random cycles, decode checks.
// Assumes a ready/valid request and a low-going cycle strobe.
`timescale 1ns/1ps
`default_nettype none
module ebcs_bus_tb_top;
    import ebcs_pkg::*;
    logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, req_valid = 0;
    logic hold_req = 0, hold_ack, req_ready, rsp_valid, prev_n = 1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h1, reg_rdata, lf = 32'h57383C75;
    logic [15:0] rsp_rdata, ad_in;
    logic [1:0] ln;
    logic [2:0] q[$], qv;
    logic [16:0] rq[$], rv;
    ebcs_req_t req = '0;
    ebcs_pins_t pins;
    int miscompares = 0, checks = 0, i, n;
    initial forever #4 clk = ~clk;
    ebcs_bus i_ebcs_bus (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .hold_req(hold_req), .hold_ack(hold_ack), .ad_in(ad_in), .pins(pins));
    ebcs_partner i_ebcs_partner (.clk(clk), .strb_n(pins.strobe_pin_n),
        .ad_oe(pins.ad_oe), .ad(ad_in));
    task automatic cmp(input logic [1:0] g, input logic [1:0] e);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %0t pin mismatch", $time);
        end
    endtask
    task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %0t read data mismatch", $time);
        end
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    always @(posedge clk)
    begin
        prev_n <= pins.strobe_pin_n;
        if (prev_n && !pins.strobe_pin_n && q.size() != 0)
        begin
            qv = q.pop_front();
            cmp({pins.byte_high_enable_n, pins.addr_bit_zero},
                qv[1:0]);
            cmp({1'b0, pins.narrow_bus_size_n}, {1'b0, qv[2]});
        end
        if (rsp_valid && rq.size() != 0)
        begin
            rv = rq.pop_front();
            if (rv[16])
                cmp16(rsp_rdata, rv[15:0]);
        end
    end
    task automatic await(ref logic s);
        n = 0;
        do @(posedge clk); while (s !== 1'b1 && ++n < 300);
        if (n >= 300)
        begin
            miscompares++;
            tally_and_finish();
        end
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        cmp({pins.ctl_oe, pins.strobe_pin_n}, 2'h1);
        reset_n <= 1'b1;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        cmp({1'b0, reg_rdata[CTRL_DS_BIT]}, 2'h1);
        for (i = 0; i < 24; i++)
        begin
            if (i == 12)
            begin
                reg_wdata <= 32'h0;
                reg_wr <= 1'b1;
                @(posedge clk);
                reg_wr <= 1'b0;
            end
            lf = nx(lf);
            ln = (lf[4:3] == 2'h0) ? LANES_WORD : lf[4:3];
            req <= '{lf[0], lf[1] & lf[2], lf[5], ln, lf[25:6], lf[31:16]};
            q.push_back({!lf[5],
                (lf[1] & lf[2]) ? 2'h3 : {ln == 1, ln == 2}});
            rq.push_back({!lf[0] && !(lf[1] & lf[2]), 16'h3C5A});
            req_valid <= 1'b1;
            await(req_ready);
            req_valid <= 1'b0;
            await(rsp_valid);
        end
        hold_req <= 1'b1;
        await(hold_ack);
        cmp({pins.ctl_oe, pins.strobe_pin_n}, 2'h1);
        cmp({q.size() != 0, rq.size() != 0}, 2'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
